// ===== src/ceb_pkg.sv
package ceb_pkg;
  typedef enum logic [3:0] {
    OP_CWD, OP_CBW, OP_NOP, OP_TEST, OP_CMP,
    OP_REL, OP_REG, OP_MEM, OP_FAR, OP_FARMEM,
    OP_RET_NEAR, OP_RET_FAR, OP_INTERRUPT_RETURN
  } op_e;
  typedef enum logic [1:0] {
    DK_CODE, DK_CALL_GATE, DK_TASK_GATE, DK_TSS
  } desc_e;
endpackage

// ===== src/ceb_regs.svh
`ifndef CEB_REGS_SVH
`define CEB_REGS_SVH
// Register word offsets on the software port
`define ADR_ACC      8'h00
`define ADR_HDW      8'h04
`define ADR_BIX      8'h08
`define ADR_IP       8'h0C
`define ADR_SP       8'h10
`define ADR_CS       8'h14
`define ADR_FLG      8'h18
`define ADR_TASK     8'h1C
`define ADR_CTRL     8'h20
`define ADR_STAT     8'h24
// Flag word bit positions
`define FLG_CF       0
`define FLG_PF       2
`define FLG_AF       4
`define FLG_ZF       6
`define FLG_SF       7
`define FLG_DF       10
`define FLG_OF       11
`define FLG_NT       14
// Control word fields
`define CTRL_PROT    0
`define CTRL_CPL_LO  1
`define CTRL_CPL_HI  2
// Reset values
`define RST_WORD     16'h0000
`define RST_SP       16'hFFFE
`define RST_CTRL     3'h0
// Idle filler occupancy in clock cycles
`define NOP_CYCLES   2
`endif

// ===== src/convert_compare_branch_exec.sv
`timescale 1ns/10ps
`include "ceb_regs.svh"
module convert_compare_branch_exec (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Software register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [15:0]       reg_rdata,
  // Decoded operation
  input  wire logic         op_valid,
  output logic              op_ready,
  input  ceb_pkg::op_e      op_code,
  input  wire logic         op_call,
  input  wire logic         op_dst_byte,
  input  wire logic         op_src_byte,
  input  wire logic         op_disp8,
  input  wire logic         op_use_index,
  input  wire logic [15:0]  op_a,
  input  wire logic [15:0]  op_b,
  input  wire logic [15:0]  op_addr,
  output logic              op_done,
  output logic              op_fault,
  // Memory port, read data one cycle after mem_rd
  output logic              mem_rd,
  output logic              mem_wr,
  output logic [15:0]       mem_addr,
  output logic [15:0]       mem_wdata,
  input  wire logic [15:0]  mem_rdata,
  // Descriptor lookup for desc_sel, same cycle
  output logic [15:0]       desc_sel,
  input  ceb_pkg::desc_e    desc_kind,
  input  wire logic [1:0]   desc_dpl,
  input  wire logic [15:0]  gate_sel,
  input  wire logic [15:0]  gate_off,
  input  wire logic [15:0]  link_addr,
  input  wire logic [15:0]  cur_link_addr
);
  typedef enum logic [3:0] {
    S_IDLE, S_NOP, S_RD_OFF, S_RD_SEL, S_RESOLVE, S_PUSH,
    S_LINK, S_COMMIT, S_POP, S_TRET_RD, S_TRET, S_TRET2
  } state_e;

  state_e       state_r, state_nxt;
  logic [15:0]  acc_r, hdw_r, bix_r, ip_r, sp_r, cs_r, flg_r, task_r;
  logic [2:0]   ctrl_r;
  logic         fault_seen_r;
  logic [15:0]  tgt_off_r, tgt_sel_r, ptr_r, imm_r, new_task_r;
  logic [1:0]   cnt_r, idx_r;
  logic         call_r, far_r, pend_r, done_r, fault_r;
  logic [15:0]  acc_nxt, hdw_nxt, ip_nxt, sp_nxt, cs_nxt, flg_nxt, task_nxt;
  logic         acc_we, hdw_we, ip_we, sp_we, cs_we, flg_we, task_we;
  logic         done_nxt, fault_nxt;
  logic [15:0]  disp16, rel_tgt, ptr_addr, res, pop_word;
  logic [16:0]  dif_w;
  logic [8:0]   dif_b;
  logic         prot, same_pl;
  logic         sw_ok;

  assign prot     = ctrl_r[`CTRL_PROT];
  assign same_pl  = desc_dpl == ctrl_r[`CTRL_CPL_HI:`CTRL_CPL_LO];
  assign op_ready = state_r == S_IDLE;
  assign sw_ok    = reg_wr && state_r == S_IDLE && !op_valid;
  assign op_done  = done_r;
  assign op_fault = fault_r;
  assign desc_sel = tgt_sel_r;
  assign disp16   = op_disp8 ? {{8{op_a[7]}}, op_a[7:0]} : op_a;
  // offset sum wraps in 16 bits
  assign rel_tgt  = ip_r + disp16;
  // optional index from the base register
  assign ptr_addr = op_addr + (op_use_index ? bix_r : `RST_WORD);
  assign dif_w    = {1'b0, op_a} - {1'b0, op_b};
  assign dif_b    = {1'b0, op_a[7:0]} - {1'b0, op_b[7:0]};
  assign pop_word = mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and register next values
  always_comb begin
    state_nxt = state_r;
    acc_we = 1'b0;  acc_nxt = acc_r;
    hdw_we = 1'b0;  hdw_nxt = hdw_r;
    ip_we  = 1'b0;  ip_nxt  = ip_r;
    sp_we  = 1'b0;  sp_nxt  = sp_r;
    cs_we  = 1'b0;  cs_nxt  = cs_r;
    flg_we = 1'b0;  flg_nxt = flg_r;
    task_we = 1'b0; task_nxt = task_r;
    mem_rd = 1'b0;  mem_wr = 1'b0;
    mem_addr = `RST_WORD;
    mem_wdata = `RST_WORD;
    done_nxt = 1'b0;
    fault_nxt = 1'b0;
    res = op_a & op_b;
    case (state_r)
      S_IDLE: if (op_valid) begin
        case (op_code)
          // sign of accumulator into high data word
          ceb_pkg::OP_CWD: begin
            hdw_we = 1'b1;
            hdw_nxt = {16{acc_r[15]}};
            done_nxt = 1'b1;
          end
          // low byte sign into high byte
          ceb_pkg::OP_CBW: begin
            acc_we = 1'b1;
            acc_nxt = {{8{acc_r[7]}}, acc_r[7:0]};
            done_nxt = 1'b1;
          end
          // filler holds for a second cycle
          ceb_pkg::OP_NOP: state_nxt = S_NOP;
          ceb_pkg::OP_TEST: begin
            flg_we = 1'b1;
            flg_nxt[`FLG_OF] = 1'b0;
            flg_nxt[`FLG_DF] = 1'b0;
            flg_nxt[`FLG_SF] = op_dst_byte ? res[7] : res[15];
            flg_nxt[`FLG_ZF] = op_dst_byte ? res[7:0] == 8'h00 : res == 16'h0000;
            flg_nxt[`FLG_PF] = ~^res[7:0];
            done_nxt = 1'b1;
          end
          ceb_pkg::OP_CMP: begin
            if (op_dst_byte != op_src_byte) begin
              fault_nxt = 1'b1;
            end else begin
              flg_we = 1'b1;
              res = op_dst_byte ? {8'h00, dif_b[7:0]} : dif_w[15:0];
              flg_nxt[`FLG_CF] = op_dst_byte ? dif_b[8] : dif_w[16];
              flg_nxt[`FLG_AF] = op_a[4] ^ op_b[4] ^ res[4];
              flg_nxt[`FLG_PF] = ~^res[7:0];
              if (op_dst_byte) begin
                flg_nxt[`FLG_SF] = res[7];
                flg_nxt[`FLG_ZF] = res[7:0] == 8'h00;
                flg_nxt[`FLG_OF] = (op_a[7] ^ op_b[7]) & (res[7] ^ op_a[7]);
              end else begin
                flg_nxt[`FLG_SF] = res[15];
                flg_nxt[`FLG_ZF] = res == 16'h0000;
                flg_nxt[`FLG_OF] = (op_a[15] ^ op_b[15]) & (res[15] ^ op_a[15]);
              end
            end
            done_nxt = !(op_dst_byte != op_src_byte);
          end
          ceb_pkg::OP_REL, ceb_pkg::OP_REG: begin
            if (op_call) begin
              state_nxt = S_PUSH;
            end else begin
              ip_we = 1'b1;
              ip_nxt = op_code == ceb_pkg::OP_REL ? rel_tgt : op_a;
              done_nxt = 1'b1;
            end
          end
          ceb_pkg::OP_MEM, ceb_pkg::OP_FARMEM: begin
            mem_rd = 1'b1;
            mem_addr = ptr_addr;
            state_nxt = S_RD_OFF;
          end
          ceb_pkg::OP_FAR: state_nxt = S_RESOLVE;
          ceb_pkg::OP_RET_NEAR, ceb_pkg::OP_RET_FAR: state_nxt = S_POP;
          // nested flag picks the return kind
          ceb_pkg::OP_INTERRUPT_RETURN: state_nxt = flg_r[`FLG_NT] ? S_TRET_RD : S_POP;
          default: fault_nxt = 1'b1;
        endcase
      end
      S_NOP: begin
        done_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      S_RD_OFF: begin
        if (far_r) begin
          mem_rd = 1'b1;
          mem_addr = ptr_r + 16'h0002;
          state_nxt = S_RD_SEL;
        end else if (call_r) begin
          state_nxt = S_PUSH;
        end else begin
          // fetched word is the new offset
          ip_we = 1'b1;
          ip_nxt = pop_word;
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_RD_SEL: state_nxt = S_RESOLVE;
      S_RESOLVE: begin
        state_nxt = call_r ? S_PUSH : S_COMMIT;
        if (prot) begin
          case (desc_kind)
            ceb_pkg::DK_CODE: begin
              // far jump must stay at current level
              if (!call_r && !same_pl) begin
                fault_nxt = 1'b1;
                state_nxt = S_IDLE;
              end
            end
            ceb_pkg::DK_CALL_GATE: state_nxt = call_r ? S_PUSH : S_COMMIT;
            default: state_nxt = call_r ? S_LINK : S_COMMIT;
          endcase
        end
      end
      S_PUSH: begin
        sp_we = 1'b1;
        sp_nxt = sp_r - 16'h0002;
        mem_wr = 1'b1;
        mem_addr = sp_r - 16'h0002;
        mem_wdata = cnt_r == 2'd2 ? cs_r : ip_r;
        if (cnt_r == 2'd1) begin
          state_nxt = S_COMMIT;
        end
      end
      // old task selector into the link field
      S_LINK: begin
        mem_wr = 1'b1;
        mem_addr = link_addr;
        mem_wdata = task_r;
        task_we = 1'b1;
        task_nxt = new_task_r;
        flg_we = 1'b1;
        flg_nxt[`FLG_NT] = 1'b1;
        state_nxt = S_COMMIT;
      end
      S_COMMIT: begin
        ip_we = 1'b1;
        ip_nxt = tgt_off_r;
        cs_we = far_r;
        cs_nxt = tgt_sel_r;
        task_we = far_r && !call_r && new_task_r != task_r;
        task_nxt = new_task_r;
        done_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      S_POP: begin
        if (pend_r) begin
          case (idx_r)
            2'd1: begin
              ip_we = 1'b1;
              ip_nxt = pop_word;
            end
            2'd2: begin
              cs_we = 1'b1;
              cs_nxt = pop_word;
            end
            default: begin
              flg_we = 1'b1;
              flg_nxt = pop_word;
            end
          endcase
        end
        sp_we = 1'b1;
        if (idx_r != cnt_r) begin
          mem_rd = 1'b1;
          mem_addr = sp_r;
          sp_nxt = sp_r + 16'h0002;
        end else begin
          sp_nxt = sp_r + imm_r;
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_TRET_RD: begin
        mem_rd = 1'b1;
        mem_addr = cur_link_addr;
        state_nxt = S_TRET;
      end
      S_TRET: state_nxt = S_TRET2;
      S_TRET2: begin
        task_we = 1'b1;
        task_nxt = tgt_sel_r;
        cs_we = 1'b1;
        cs_nxt = gate_sel;
        ip_we = 1'b1;
        ip_nxt = gate_off;
        flg_we = 1'b1;
        flg_nxt[`FLG_NT] = 1'b0;
        done_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation latches
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      tgt_off_r <= `RST_WORD;
      tgt_sel_r <= `RST_WORD;
      new_task_r <= `RST_WORD;
      ptr_r <= `RST_WORD;
      imm_r <= `RST_WORD;
      cnt_r <= 2'd0;
      idx_r <= 2'd0;
      call_r <= 1'b0;
      far_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= mem_rd && state_r == S_POP;
      if (state_r == S_IDLE && op_valid) begin
        call_r <= op_call;
        far_r <= op_code == ceb_pkg::OP_FAR || op_code == ceb_pkg::OP_FARMEM;
        ptr_r <= ptr_addr;
        // offset from the instruction, selector from op_b for OP_FAR, else cs_r
        tgt_off_r <= op_code == ceb_pkg::OP_REL ? rel_tgt : op_a;
        tgt_sel_r <= op_code == ceb_pkg::OP_FAR ? op_b : cs_r;
        new_task_r <= task_r;
        imm_r <= op_code == ceb_pkg::OP_INTERRUPT_RETURN ? `RST_WORD : op_b;
        idx_r <= 2'd0;
        case (op_code)
          ceb_pkg::OP_RET_NEAR: cnt_r <= 2'd1;
          ceb_pkg::OP_RET_FAR: cnt_r <= 2'd2;
          ceb_pkg::OP_INTERRUPT_RETURN: cnt_r <= 2'd3;
          ceb_pkg::OP_FAR, ceb_pkg::OP_FARMEM: cnt_r <= 2'd2;
          default: cnt_r <= 2'd1;
        endcase
      end
      // first word offset, second word selector
      if (state_r == S_RD_OFF) begin
        tgt_off_r <= pop_word;
      end
      if (state_r == S_RD_SEL) begin
        tgt_sel_r <= pop_word;
      end
      if (state_r == S_TRET) begin
        tgt_sel_r <= pop_word;
      end
      if (state_r == S_RESOLVE && prot) begin
        if (desc_kind != ceb_pkg::DK_CODE) begin
          tgt_sel_r <= gate_sel;
          tgt_off_r <= gate_off;
        end
        // task targets only honoured when protected
        if (desc_kind == ceb_pkg::DK_TASK_GATE || desc_kind == ceb_pkg::DK_TSS) begin
          new_task_r <= tgt_sel_r;
        end
      end
      if (state_r == S_PUSH) begin
        cnt_r <= cnt_r - 2'd1;
      end
      if (state_r == S_POP) begin
        idx_r <= idx_r + 2'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural registers; operations win over software writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_r <= `RST_WORD;
      hdw_r <= `RST_WORD;
      bix_r <= `RST_WORD;
    end else begin
      if (acc_we) acc_r <= acc_nxt;
      else if (sw_ok && reg_addr == `ADR_ACC) acc_r <= reg_wdata;
      if (hdw_we) hdw_r <= hdw_nxt;
      else if (sw_ok && reg_addr == `ADR_HDW) hdw_r <= reg_wdata;
      if (sw_ok && reg_addr == `ADR_BIX) bix_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ip_r <= `RST_WORD;
      cs_r <= `RST_WORD;
      task_r <= `RST_WORD;
    end else begin
      if (ip_we) ip_r <= ip_nxt;
      else if (sw_ok && reg_addr == `ADR_IP) ip_r <= reg_wdata;
      if (cs_we) cs_r <= cs_nxt;
      else if (sw_ok && reg_addr == `ADR_CS) cs_r <= reg_wdata;
      if (task_we) task_r <= task_nxt;
      else if (sw_ok && reg_addr == `ADR_TASK) task_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sp_r <= `RST_SP;
      flg_r <= `RST_WORD;
      ctrl_r <= `RST_CTRL;
    end else begin
      if (sp_we) sp_r <= sp_nxt;
      else if (sw_ok && reg_addr == `ADR_SP) sp_r <= reg_wdata;
      if (flg_we) flg_r <= flg_nxt;
      else if (sw_ok && reg_addr == `ADR_FLG) flg_r <= reg_wdata;
      if (sw_ok && reg_addr == `ADR_CTRL) ctrl_r <= reg_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion pulses, sticky fault and read port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
      fault_seen_r <= 1'b0;
      reg_rdata <= `RST_WORD;
    end else begin
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      // Set wins over a same-cycle clear
      if (fault_nxt) fault_seen_r <= 1'b1;
      else if (sw_ok && reg_addr == `ADR_STAT) fault_seen_r <= 1'b0;
      reg_rdata <= `RST_WORD;
      if (reg_rd) begin
        case (reg_addr)
          `ADR_ACC:  reg_rdata <= acc_r;
          `ADR_HDW:  reg_rdata <= hdw_r;
          `ADR_BIX:  reg_rdata <= bix_r;
          `ADR_IP:   reg_rdata <= ip_r;
          `ADR_SP:   reg_rdata <= sp_r;
          `ADR_CS:   reg_rdata <= cs_r;
          `ADR_FLG:  reg_rdata <= flg_r;
          `ADR_TASK: reg_rdata <= task_r;
          `ADR_CTRL: reg_rdata <= {13'h0000, ctrl_r};
          `ADR_STAT: reg_rdata <= {14'h0000, fault_seen_r, state_r != S_IDLE};
          default:   reg_rdata <= `RST_WORD;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_cwd_fill: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && op_code == ceb_pkg::OP_CWD
    |=> hdw_r == {16{$past(acc_r[15])}} && flg_r == $past(flg_r))
    else $error("sign fill of high data word wrong");
  chk_cbw_fill: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && op_code == ceb_pkg::OP_CBW
    |=> acc_r[15:8] == {8{$past(acc_r[7])}} && flg_r == $past(flg_r))
    else $error("byte sign extension wrong");
  chk_nop_time: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && op_code == ceb_pkg::OP_NOP
    |=> !op_ready && !op_done ##1 op_ready && op_done)
    else $error("filler did not take two cycles");
  chk_test_keep: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && op_code == ceb_pkg::OP_TEST
    |=> acc_r == $past(acc_r) && !flg_r[`FLG_OF] && !flg_r[`FLG_DF])
    else $error("flag-only and disturbed state");
  chk_cmp_size: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && op_code == ceb_pkg::OP_CMP && op_dst_byte != op_src_byte
    |=> op_fault && !op_done && $stable(flg_r))
    else $error("mixed size compare accepted");
  chk_jmp_nopush: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && !op_call && op_code == ceb_pkg::OP_FAR
    |-> !mem_wr [*4])
    else $error("jump wrote the stack");
  chk_rel_target: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && !op_call && op_code == ceb_pkg::OP_REL
    |=> ip_r == $past(rel_tgt) && op_done)
    else $error("relative target wrong");
  chk_ret_count: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && op_code == ceb_pkg::OP_RET_NEAR
    |-> ##3 sp_r == $past(sp_r, 3) + 16'h0002 + $past(op_b, 3) && op_done)
    else $error("return count not applied");
  chk_interrupt_return_nested: assert property (@(posedge clk) disable iff (sys_rst)
    op_ready && op_valid && op_code == ceb_pkg::OP_INTERRUPT_RETURN && flg_r[`FLG_NT]
    |=> mem_rd && mem_addr == cur_link_addr ##3 !flg_r[`FLG_NT] && op_done)
    else $error("nested interrupt return did not switch");
endmodule // convert_compare_branch_exec

// ===== tb/sys_mem_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Stack and pointer memory plus descriptor table seen by the executor
module sys_mem_model (
  // Clock
  input  wire logic        clk,
  // Memory port
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  // Descriptor lookup
  input  wire logic [15:0] desc_sel,
  output ceb_pkg::desc_e   desc_kind,
  output logic      [1:0]  desc_dpl,
  output logic      [15:0] gate_sel,
  output logic      [15:0] gate_off
);
  logic [15:0] mem [0:127];
  // Idle bus shows inverted data so a late sample cannot pass
  // Plain always so the bench may preload words between edges
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr[7:1]] : ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr[7:1]] <= mem_wdata;
    end
  end
  // Selector 0010 is a call gate, 0018 a task segment, 0028 code at level 3
  always_comb begin
    desc_kind = ceb_pkg::DK_CODE;
    if (desc_sel == 16'h0010) desc_kind = ceb_pkg::DK_CALL_GATE;
    if (desc_sel == 16'h0018) desc_kind = ceb_pkg::DK_TSS;
    desc_dpl  = (desc_sel == 16'h0028) ? 2'h3 : 2'h0;
    gate_sel  = 16'h0020;
    gate_off  = 16'h1234;
  end
endmodule // sys_mem_model

// ===== tb/tb.sv
`timescale 1ns/10ps
`include "ceb_regs.svh"
module tb;
  logic           clk, sys_rst, reg_wr, reg_rd, op_valid, op_call, op_dst_byte;
  logic           op_src_byte, op_disp8, op_use_index, op_ready, op_done, op_fault;
  logic           mem_rd, mem_wr;
  logic [7:0]     reg_addr;
  logic [1:0]     desc_dpl;
  logic [15:0]    reg_wdata, reg_rdata, op_a, op_b, op_addr, mem_addr, mem_wdata;
  logic [15:0]    mem_rdata, desc_sel, gate_sel, gate_off;
  ceb_pkg::op_e   op_code;
  ceb_pkg::desc_e desc_kind;
  int             errors, checks_done, wcnt, n;
  convert_compare_branch_exec convert_compare_branch_exec_inst (.clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_valid, .op_ready,
    .op_code, .op_call, .op_dst_byte, .op_src_byte, .op_disp8, .op_use_index,
    .op_a, .op_b, .op_addr, .op_done, .op_fault, .mem_rd, .mem_wr, .mem_addr,
    .mem_wdata, .mem_rdata, .desc_sel, .desc_kind, .desc_dpl, .gate_sel,
    .gate_off, .link_addr(16'h0040), .cur_link_addr(16'h0040));
  sys_mem_model sys_mem_model_inst (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
    .mem_rdata, .desc_sel, .desc_kind, .desc_dpl, .gate_sel, .gate_off);
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  // Mode bits: call, dst byte, src byte, disp8, indexed
  task automatic op(input ceb_pkg::op_e c, input logic [4:0] m, input logic [15:0] a = 16'h0,
                    input logic [15:0] b = 16'h0, input logic [15:0] ad = 16'h0);
    @(posedge clk);
    op_code <= c;
    {op_call, op_dst_byte, op_src_byte, op_disp8, op_use_index} <= m;
    op_a     <= a;
    op_b     <= b;
    op_addr  <= ad;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    n    = 0;
    wcnt = 0;
    #1;
    while (op_done !== 1'b1 && op_fault !== 1'b1) begin
      @(posedge clk);
      n++;
      #1;
      if (mem_wr === 1'b1) wcnt++;
      if (n > 40) begin
        errors++;
        end_sim();
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_conv;
    rc("sp", `ADR_SP, 16'hFFFE);
    rc("unmapped", 8'h30, 16'h0000);
    wr(`ADR_FLG, 16'h08D5);
    wr(`ADR_ACC, 16'h8000);
    op(ceb_pkg::OP_CWD, 5'h00);
    rc("hdw", `ADR_HDW, 16'hFFFF);
    wr(`ADR_ACC, 16'h7FFF);
    op(ceb_pkg::OP_CWD, 5'h00);
    rc("hdw", `ADR_HDW, 16'h0000);
    wr(`ADR_ACC, 16'h1280);
    op(ceb_pkg::OP_CBW, 5'h00);
    rc("acc", `ADR_ACC, 16'hFF80);
    rc("flags", `ADR_FLG, 16'h08D5);
    wr(`ADR_IP, 16'h0100);
    op(ceb_pkg::OP_NOP, 5'h00);
    // Taking edge is the first cycle, so occupancy is n plus one
    chk("nop cycles", 16'(`NOP_CYCLES), 16'(n + 1));
    rc("ip", `ADR_IP, 16'h0100);
  endtask
  task automatic t_flags;
    wr(`ADR_FLG, 16'h0C10);
    op(ceb_pkg::OP_TEST, 5'h00, 16'h8001, 16'hC000);
    rc("test flags", `ADR_FLG, 16'h0094);
    rc("acc", `ADR_ACC, 16'hFF80);
    wr(`ADR_FLG, 16'h0000);
    op(ceb_pkg::OP_CMP, 5'h00, 16'h0001, 16'h0002);
    rc("cmp word", `ADR_FLG, 16'h0095);
    op(ceb_pkg::OP_CMP, 5'h0C, 16'h0080, 16'h0001);
    rc("cmp byte", `ADR_FLG, 16'h0810);
    op(ceb_pkg::OP_CMP, 5'h08, 16'h0001, 16'h0002);
    chk("mixed fault", 16'h1, {15'h0, op_fault});
    rc("flags kept", `ADR_FLG, 16'h0810);
  endtask
  task automatic t_near;
    wr(`ADR_IP, 16'hFFF0);
    op(ceb_pkg::OP_REL, 5'h02, 16'h0020);
    rc("ip wrap", `ADR_IP, 16'h0010);
    op(ceb_pkg::OP_REL, 5'h00, 16'h8000);
    rc("ip disp16", `ADR_IP, 16'h8010);
    chk("jump pushes", 16'h0, wcnt[15:0]);
    op(ceb_pkg::OP_REG, 5'h00, 16'h4321);
    rc("ip reg", `ADR_IP, 16'h4321);
    sys_mem_model_inst.mem[8'h0A] = 16'h5555;
    wr(`ADR_BIX, 16'h0004);
    op(ceb_pkg::OP_MEM, 5'h01, 16'h0, 16'h0, 16'h0010);
    rc("ip mem", `ADR_IP, 16'h5555);
  endtask
  task automatic t_call;
    wr(`ADR_IP, 16'h0300);
    wr(`ADR_CS, 16'h0007);
    op(ceb_pkg::OP_FAR, 5'h10, 16'h2000, 16'h0008);
    rc("cs", `ADR_CS, 16'h0008);
    rc("ip", `ADR_IP, 16'h2000);
    rc("sp", `ADR_SP, 16'hFFFA);
    chk("push cs", 16'h0007, sys_mem_model_inst.mem[8'h7E]);
    chk("push ip", 16'h0300, sys_mem_model_inst.mem[8'h7D]);
    // Even count, as software must supply
    op(ceb_pkg::OP_RET_FAR, 5'h00, 16'h0, 16'h0004);
    rc("ret cs", `ADR_CS, 16'h0007);
    rc("ret ip", `ADR_IP, 16'h0300);
    rc("ret sp", `ADR_SP, 16'h0002);
    wr(`ADR_IP, 16'h0400);
    op(ceb_pkg::OP_REL, 5'h10, 16'h0010);
    chk("near push", 16'h0400, sys_mem_model_inst.mem[8'h00]);
    op(ceb_pkg::OP_RET_NEAR, 5'h00);
    rc("near ret ip", `ADR_IP, 16'h0400);
    rc("near ret sp", `ADR_SP, 16'h0002);
  endtask
  task automatic t_far;
    op(ceb_pkg::OP_FAR, 5'h00, 16'h00AB, 16'h0010);
    rc("real gate", `ADR_CS, 16'h0010);
    wr(`ADR_CTRL, 16'h0001);
    op(ceb_pkg::OP_FAR, 5'h00, 16'h9999, 16'h0010);
    rc("gate cs", `ADR_CS, 16'h0020);
    rc("gate ip", `ADR_IP, 16'h1234);
    chk("far jump pushes", 16'h0, wcnt[15:0]);
    op(ceb_pkg::OP_FAR, 5'h00, 16'h7777, 16'h0028);
    chk("level fault", 16'h1, {15'h0, op_fault});
    rc("cs kept", `ADR_CS, 16'h0020);
    sys_mem_model_inst.mem[8'h30] = 16'h0700;
    sys_mem_model_inst.mem[8'h31] = 16'h0030;
    op(ceb_pkg::OP_FARMEM, 5'h00, 16'h0, 16'h0, 16'h0060);
    rc("farmem cs", `ADR_CS, 16'h0030);
    rc("farmem ip", `ADR_IP, 16'h0700);
  endtask
  task automatic t_task;
    wr(`ADR_TASK, 16'h0048);
    op(ceb_pkg::OP_FAR, 5'h10, 16'h0, 16'h0018);
    rc("task in", `ADR_TASK, 16'h0018);
    rc("nested set", `ADR_FLG, 16'h4810);
    chk("link", 16'h0048, sys_mem_model_inst.mem[8'h20]);
    op(ceb_pkg::OP_INTERRUPT_RETURN, 5'h00);
    rc("task back", `ADR_TASK, 16'h0048);
    rc("nested clr", `ADR_FLG, 16'h0810);
    sys_mem_model_inst.mem[8'h01] = 16'h0222;
    sys_mem_model_inst.mem[8'h02] = 16'h0033;
    sys_mem_model_inst.mem[8'h03] = 16'h00C4;
    op(ceb_pkg::OP_INTERRUPT_RETURN, 5'h00);
    rc("interrupt_return ip", `ADR_IP, 16'h0222);
    rc("interrupt_return cs", `ADR_CS, 16'h0033);
    rc("interrupt_return flags", `ADR_FLG, 16'h00C4);
    rc("interrupt_return sp", `ADR_SP, 16'h0008);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, op_valid} = 4'h8;
    {op_call, op_dst_byte, op_src_byte, op_disp8, op_use_index} = 5'h00;
    {reg_addr, reg_wdata, op_a, op_b, op_addr} = '0;
    op_code = ceb_pkg::OP_NOP;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_conv();
    t_flags();
    t_near();
    t_call();
    t_far();
    t_task();
    end_sim();
  end
endmodule // tb
